/* msws_top.sv */
// mode select, sleep control, host reset and window watchdog
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module msws_top #(
   parameter int rst_pulse_len = msws_pkg::rst_pulse_cycles,
   parameter int holdoff_len = msws_pkg::holdoff_cycles,
   parameter int bus_wake_len = msws_pkg::bus_wake_cycles,
   parameter int tick_len = msws_pkg::tick_cycles,
   parameter logic [31:0] nonvolatile_defaults = 32'h0000_0000
)(
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic bus_pin_in, // bus pin level (async)
   input wire logic key_switch_input, // key switch (async)
   input wire logic host_heartbeat_in, // heartbeat (async)
   input wire logic [9:0] pwm_demand_value, // duty measured on bus pin
   input wire logic ext_reg_uv, // external regulator undervoltage
   input wire logic pump_good, // charge pump good (async)
   output logic [9:0] demand_value, // selected demand
   output logic host_reset_n, // host reset, low active
   output logic regulators_on, // regulators and clock enable
   output logic drive_enable, // gate drive allowed
   output logic motor_restart // restart request pulse
);
   // ***********************************************
   // input synchronisers
   // ***********************************************
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic bus_s, key_s, hb_s, pump_s;
   // two flops per async input
   always_ff @(posedge aclk)
   begin
      sync_a <= {pump_good, host_heartbeat_in, key_switch_input, bus_pin_in};
      sync_b <= sync_a;
   end
   assign bus_s = sync_b[0];
   assign key_s = sync_b[1];
   assign hb_s = sync_b[2];
   assign pump_s = sync_b[3];
   logic bus_d, key_d, hb_d;
   always_ff @(posedge aclk)
   begin
      bus_d <= bus_s;
      key_d <= key_s;
      hb_d <= hb_s;
   end
   logic hb_edge, key_rise, key_fall;
   assign hb_edge = hb_s ^ hb_d;
   assign key_rise = key_s & ~key_d;
   assign key_fall = ~key_s & key_d;

   // ***********************************************
   // registers and AXI4-Lite slave
   // ***********************************************
   logic [31:0] ctrl, wdcfg, demand_reg;
   logic asleep, perm_sleep, wd_fault, first_xfer;
   logic aw_hold, w_hold;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic wd_set, wake, sleep_go;
   logic do_write;
   assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
   assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
   // address and data capture in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn || do_write)
      begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
         end
      end
   end
   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_bvalid <= 1'b0;
      else if (do_write)
         s_axi_bvalid <= 1'b1;
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end
   assign s_axi_bresp = 2'h0;
   // register writes; waking reloads defaults
   always_ff @(posedge aclk)
   begin
      if (!aresetn || wake)
      begin
         ctrl <= nonvolatile_defaults;
         wdcfg <= 32'h0000_0000;
         demand_reg <= 32'h0000_0000;
      end
      else if (do_write && !asleep)
      begin
         case (aw_addr)
            msws_pkg::ctrl_addr: ctrl <= w_data;
            msws_pkg::wdcfg_addr: wdcfg <= w_data;
            msws_pkg::demand_addr: demand_reg <= w_data;
            default: ;
         endcase
      end
   end
   // first valid serial transfer since power-up or wake
   always_ff @(posedge aclk)
   begin
      if (!aresetn || wake)
         first_xfer <= 1'b0;
      else if (do_write)
         first_xfer <= 1'b1;
   end
   // read channel
   logic [31:0] status_word;
   assign status_word = {27'h0, ~host_reset_n, drive_enable, perm_sleep,
      asleep, wd_fault};
   assign s_axi_arready = ~s_axi_rvalid;
   assign s_axi_rresp = 2'h0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            msws_pkg::ctrl_addr: s_axi_rdata <= ctrl;
            msws_pkg::wdcfg_addr: s_axi_rdata <= wdcfg;
            msws_pkg::demand_addr: s_axi_rdata <= demand_reg;
            msws_pkg::status_addr: s_axi_rdata <= status_word;
            default: s_axi_rdata <= 32'h0;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
   logic operating_style_select, go_to_sleep_request, wake_style_select;
   logic wd_mask;
   logic [3:0] fail_cycle_limit;
   logic [7:0] heartbeat_min_interval, heartbeat_window_length;
   assign operating_style_select = ctrl[msws_pkg::ctrl_opm_bit];
   assign go_to_sleep_request = ctrl[msws_pkg::ctrl_gts_bit];
   assign wake_style_select = ctrl[msws_pkg::ctrl_lwk_bit];
   assign wd_mask = ctrl[msws_pkg::ctrl_wdmask_bit];
   assign heartbeat_min_interval = wdcfg[7:0];
   assign heartbeat_window_length = wdcfg[15:8];
   assign fail_cycle_limit = wdcfg[19:16];

   // ***********************************************
   // demand selection
   // ***********************************************
   always_ff @(posedge aclk)
   begin
      if (operating_style_select)
         demand_value <= pwm_demand_value;
      else
         demand_value <= demand_reg[9:0];
   end

   // ***********************************************
   // sleep and wake
   // ***********************************************
   logic gts_d, perm_go;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         gts_d <= 1'b0;
      else
         gts_d <= go_to_sleep_request;
   end
   // sleep request on 0-to-1; a missed one needs a fresh 0 then 1
   assign sleep_go = !asleep && ((go_to_sleep_request && !gts_d &&
      (operating_style_select || bus_s))
      || (operating_style_select && key_fall));
   // bus wake timing
   logic [31:0] wake_cnt;
   logic bus_wake, bus_wake_lvl;
   always_ff @(posedge aclk)
   begin
      if (!asleep || bus_s != bus_d)
         wake_cnt <= 32'h0;
      else if (wake_cnt < 32'(bus_wake_len) + 32'h1)
         wake_cnt <= wake_cnt + 32'h1;
   end
   always_comb
   begin
      if (wake_style_select)
         bus_wake = bus_s && !bus_d &&
            wake_cnt > 32'(bus_wake_len);
      else
         bus_wake = wake_cnt == 32'(bus_wake_len) &&
            bus_s != bus_wake_lvl;
   end
   // level at sleep entry; a change held long wakes
   always_ff @(posedge aclk)
   begin
      if (!asleep || bus_wake)
         bus_wake_lvl <= bus_s;
   end
   // permanent sleep ignores every wake source
   assign wake = asleep && !perm_sleep
      && (bus_wake || key_rise);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         asleep <= 1'b0;
         perm_sleep <= 1'b0;
      end
      else if (perm_go)
      begin
         asleep <= 1'b1;
         perm_sleep <= 1'b1;
      end
      else if (sleep_go)
         asleep <= 1'b1;
      else if (wake)
         asleep <= 1'b0;
   end
   assign regulators_on = ~asleep;

   // ***********************************************
   // host reset and watchdog
   // ***********************************************
   msws_pkg::msws_wd_type wd_state;
   logic [31:0] wd_cnt, tick_cnt, ms_cnt;
   logic [3:0] fail_cnt;
   logic drive_block, early, late, hold_low, mask_cut;
   assign hold_low = asleep || ext_reg_uv;
   logic boot_phase;
   // power-up or wake pulse, the only pulse a serial write may cut short
   always_ff @(posedge aclk)
   begin
      if (!aresetn || wake)
         boot_phase <= 1'b1;
      else if (wd_state == msws_pkg::st_holdoff)
         boot_phase <= 1'b0;
   end
   assign mask_cut = wd_mask && first_xfer && boot_phase;
   assign early = hb_edge && ms_cnt < 32'(heartbeat_min_interval);
   assign late = ms_cnt >= 32'(heartbeat_min_interval) +
      32'(heartbeat_window_length);
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_low || wd_state != msws_pkg::st_run || hb_edge
         || tick_cnt == 32'(tick_len) - 32'h1)
         tick_cnt <= 32'h0;
      else
         tick_cnt <= tick_cnt + 32'h1;
   end
   // ms interval counter since last edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_low || wd_state != msws_pkg::st_run || hb_edge)
         ms_cnt <= 32'h0;
      else if (tick_cnt == 32'(tick_len) - 32'h1)
         ms_cnt <= ms_cnt + 32'h1;
   end
   logic first_edge;
   assign wd_set = !wd_mask && wd_state == msws_pkg::st_run &&
      ((early && !first_edge) || late);
   assign perm_go = wd_set && fail_cycle_limit != 4'h0 &&
      fail_cnt == fail_cycle_limit;
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_low)
      begin
         wd_state <= msws_pkg::st_reset;
         wd_cnt <= 32'h0;
         first_edge <= 1'b1;
      end
      else
      begin
         case (wd_state)
            msws_pkg::st_reset:
               if (mask_cut || wd_cnt >= 32'(rst_pulse_len) - 32'h1)
               begin
                  wd_state <= msws_pkg::st_holdoff;
                  wd_cnt <= 32'h0;
               end
               else
                  wd_cnt <= wd_cnt + 32'h1;
            msws_pkg::st_holdoff:
               if (wd_cnt >= 32'(holdoff_len) - 32'h1)
               begin
                  wd_state <= msws_pkg::st_run;
                  first_edge <= 1'b1;
               end
               else
                  wd_cnt <= wd_cnt + 32'h1;
            msws_pkg::st_run:
               if (wd_set)
               begin
                  wd_state <= msws_pkg::st_reset;
                  wd_cnt <= 32'h0;
               end
               else if (hb_edge)
                  first_edge <= 1'b0;
            default: wd_state <= msws_pkg::st_reset;
         endcase
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         host_reset_n <= 1'b0;
      else
         host_reset_n <= !hold_low
            && wd_state != msws_pkg::st_reset;
   end
   // fail counter, fault flag, drive block
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_low)
      begin
         fail_cnt <= 4'h0;
         wd_fault <= 1'b0;
         drive_block <= 1'b0;
         motor_restart <= 1'b0;
      end
      else
      begin
         motor_restart <= 1'b0;
         if (wd_set)
         begin
            fail_cnt <= fail_cnt + 4'h1;
            wd_fault <= 1'b1;
            drive_block <= 1'b1;
         end
         else
         begin
            if (do_write && aw_addr == msws_pkg::stclr_addr &&
               w_data[msws_pkg::st_wd_bit])
               wd_fault <= 1'b0;
            if (wd_state == msws_pkg::st_run && hb_edge)
            begin
               fail_cnt <= 4'h0;
               drive_block <= 1'b0;
               motor_restart <= drive_block && ctrl[msws_pkg::ctrl_run_bit]
                  && ctrl[msws_pkg::ctrl_rsc_bit]
                  && demand_value != 10'h000;
            end
         end
      end
   end
   assign drive_enable = pump_s && !asleep && host_reset_n
      && !drive_block;

   // ***********************************************
   // assertions
   // ***********************************************
   property p_sleep_reset;
      @(posedge aclk) disable iff (!aresetn) asleep |=> !host_reset_n;
   endproperty
   a_sleep_reset: assert property (p_sleep_reset)
      else $error("host reset not low in sleep");
   property p_perm_stays;
      @(posedge aclk) disable iff (!aresetn) perm_sleep |=> asleep;
   endproperty
   a_perm_stays: assert property (p_perm_stays)
      else $error("left permanent sleep");
   property p_fault_reset;
      @(posedge aclk) disable iff (!aresetn) wd_set |=> ##1 !host_reset_n;
   endproperty
   a_fault_reset: assert property (p_fault_reset)
      else $error("fault did not pulse reset");
   property p_mask;
      @(posedge aclk) disable iff (!aresetn) wd_mask |-> !wd_set;
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked watchdog acted");
   property p_block;
      @(posedge aclk) disable iff (!aresetn) wd_set |=> !drive_enable;
   endproperty
   a_block: assert property (p_block)
      else $error("drive on after failure");
   property p_pump;
      @(posedge aclk) disable iff (!aresetn) !pump_s |-> !drive_enable;
   endproperty
   a_pump: assert property (p_pump)
      else $error("drive on before pump good");
   property p_reg_off;
      @(posedge aclk) disable iff (!aresetn) sleep_go |=> !regulators_on;
   endproperty
   a_reg_off: assert property (p_reg_off)
      else $error("regulators on in sleep");
   property p_sticky;
      @(posedge aclk) disable iff (!aresetn)
         wd_fault && !hold_low && !do_write |=> wd_fault;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("fault flag dropped");
endmodule

/* msws_pkg.sv */
// package of constants for the mode, sleep and watchdog supervisor
package msws_pkg;
   // ***********************************************
   // register map (byte offsets)
   // ***********************************************
   localparam logic [7:0] ctrl_addr = 8'h00;
   localparam logic [7:0] wdcfg_addr = 8'h04;
   localparam logic [7:0] demand_addr = 8'h08;
   localparam logic [7:0] status_addr = 8'h0C;
   localparam logic [7:0] stclr_addr = 8'h10;
   // ctrl field positions
   localparam int ctrl_opm_bit = 0;
   localparam int ctrl_gts_bit = 1;
   localparam int ctrl_lwk_bit = 2;
   localparam int ctrl_wdmask_bit = 3;
   localparam int ctrl_run_bit = 4;
   localparam int ctrl_rsc_bit = 5;
   // status field positions
   localparam int st_wd_bit = 0;
   localparam int st_sleep_bit = 1;
   localparam int st_perm_bit = 2;
   localparam int st_drv_bit = 3;
   localparam int st_rst_bit = 4;
   // ***********************************************
   // timing
   // ***********************************************
   localparam int clk_mhz = 125;
   localparam int rst_pulse_ms = 10;
   localparam int holdoff_ms = 100;
   localparam int bus_wake_us = 50;
   localparam int rst_pulse_cycles = rst_pulse_ms * 1000 * clk_mhz;
   localparam int holdoff_cycles = holdoff_ms * 1000 * clk_mhz;
   localparam int bus_wake_cycles = bus_wake_us * clk_mhz;
   localparam int tick_cycles = 1000 * clk_mhz; // one interval unit = 1 ms
   localparam logic [31:0] resp_okay = 32'h0;
   typedef enum {st_reset, st_holdoff, st_run} msws_wd_type;
endpackage

/* msws_host_model.sv */
// heartbeat source standing in for the host controller
`timescale 1ns/1ps
module msws_host_model (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, low
   input wire logic [7:0] hb_period, // cycles per level, 0 stops
   output logic host_heartbeat_in // heartbeat to the device
);
   logic [7:0] hb_count;
   // hold each level for the set period, then toggle
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hb_period == 8'h00)
      begin
         hb_count <= 8'h00;
      end
      else if (hb_count + 8'h01 >= hb_period)
      begin
         hb_count <= 8'h00;
      end
      else
      begin
         hb_count <= hb_count + 8'h01;
      end
   end
   // output level, parked low in reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         host_heartbeat_in <= 1'b0;
      end
      else if (hb_period != 8'h00 && hb_count + 8'h01 >= hb_period)
      begin
         host_heartbeat_in <= ~host_heartbeat_in;
      end
   end
endmodule

/* mode_sleep_watchdog_supervisor_bench.sv */
// self-checking bench for the mode, sleep and watchdog supervisor
`timescale 1ns/1ps
module mode_sleep_watchdog_supervisor_bench;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, hb_period;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic bus_pin, key_sw, heartbeat, uv, pump_good;
   logic [9:0] pwm_demand, demand;
   logic host_reset_n, regs_on, drive_en, restart;
   int fail_count = 0, checks = 0, cycles = 0, restarts = 0, r0;
   msws_top #(.rst_pulse_len(20), .holdoff_len(40), .bus_wake_len(10),
      .tick_len(4), .nonvolatile_defaults(32'h0000_0008)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .bus_pin_in(bus_pin),
      .key_switch_input(key_sw), .host_heartbeat_in(heartbeat),
      .pwm_demand_value(pwm_demand), .ext_reg_uv(uv),
      .pump_good(pump_good), .demand_value(demand),
      .host_reset_n(host_reset_n), .regulators_on(regs_on),
      .drive_enable(drive_en), .motor_restart(restart));
   msws_host_model u_host (.aclk(aclk), .aresetn(aresetn),
      .hb_period(hb_period), .host_heartbeat_in(heartbeat));
   // 8 ns clock
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // cycle limit and restart pulse counter
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (restart === 1'b1) restarts <= restarts + 1;
      if (cycles == 30000)
      begin
         fail_count = fail_count + 1;
         stop_test;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one write: address and data together, wait for the response
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   // one read, data taken at the rvalid edge
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return host_reset_n;
         1: return regs_on;
         default: return drive_en;
      endcase
   endfunction
   // bounded wait for an output level, then compare
   task automatic wait_for(input int sel, input logic v, input int lim);
      int n;
      n = 0;
      while (pick(sel) !== v && n < lim)
      begin
         @(posedge aclk);
         n = n + 1;
      end
      check(pick(sel), v);
   endtask
   // ***********************************************
   // test sequence
   // ***********************************************
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, hb_period, wdata, wstrb} = 60'h0;
      {bus_pin, key_sw, uv, pump_good} = 4'h1;
      pwm_demand = 10'h000;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      check(host_reset_n, 1'b0);
      axi_wr(msws_pkg::ctrl_addr, 32'h08);
      wait_for(0, 1'b1, 6);
      pump_good <= 1'b1;
      wait_for(2, 1'b1, 6);
      pump_good <= 1'b0;
      wait_for(2, 1'b0, 6);
      pump_good <= 1'b1;
      uv <= 1'b1;
      wait_for(0, 1'b0, 5);
      uv <= 1'b0;
      repeat (12) @(posedge aclk);
      check(host_reset_n, 1'b0);
      wait_for(0, 1'b1, 20);
      axi_wr(msws_pkg::demand_addr, 32'h2AB);
      repeat (2) @(posedge aclk);
      check(demand, 10'h2AB);
      pwm_demand <= 10'h155;
      axi_wr(msws_pkg::ctrl_addr, 32'h09);
      axi_wr(msws_pkg::demand_addr, 32'h0F0);
      repeat (2) @(posedge aclk);
      check(demand, 10'h155);
      // serial sleep needs the pin high and a fresh 0 then 1
      bus_pin <= 1'b0;
      axi_wr(msws_pkg::ctrl_addr, 32'h08);
      axi_wr(msws_pkg::ctrl_addr, 32'h0E);
      bus_pin <= 1'b1;
      repeat (20) @(posedge aclk);
      check(regs_on, 1'b1);
      axi_wr(msws_pkg::ctrl_addr, 32'h0E);
      repeat (20) @(posedge aclk);
      check(regs_on, 1'b1);
      axi_wr(msws_pkg::ctrl_addr, 32'h0C);
      axi_wr(msws_pkg::ctrl_addr, 32'h0E);
      wait_for(1, 1'b0, 20);
      // host reset follows sleep one edge later
      @(posedge aclk);
      check(host_reset_n, 1'b0);
      check(drive_en, 1'b0);
      bus_pin <= 1'b0;
      repeat (5) @(posedge aclk);
      bus_pin <= 1'b1;
      repeat (30) @(posedge aclk);
      check(regs_on, 1'b0);
      bus_pin <= 1'b0;
      repeat (30) @(posedge aclk);
      check(regs_on, 1'b0);
      bus_pin <= 1'b1;
      wait_for(1, 1'b1, 30);
      axi_rd(msws_pkg::ctrl_addr, rv);
      check(rv, 32'h08);
      axi_rd(msws_pkg::status_addr, rv);
      check(rv[0], 1'b0);
      // standalone sleep and wake paths
      bus_pin <= 1'b0;
      axi_wr(msws_pkg::ctrl_addr, 32'h09);
      axi_wr(msws_pkg::ctrl_addr, 32'h0B);
      wait_for(1, 1'b0, 20);
      key_sw <= 1'b1;
      wait_for(1, 1'b1, 20);
      axi_wr(msws_pkg::ctrl_addr, 32'h09);
      key_sw <= 1'b0;
      wait_for(1, 1'b0, 20);
      bus_pin <= 1'b1;
      wait_for(1, 1'b1, 40);
      // missing edge, recovery, restart and sticky fault
      axi_wr(msws_pkg::wdcfg_addr, 32'h0000_0402);
      axi_wr(msws_pkg::demand_addr, 32'h100);
      axi_wr(msws_pkg::ctrl_addr, 32'h30);
      wait_for(0, 1'b0, 100);
      r0 = restarts;
      hb_period <= 8'h10;
      check(drive_en, 1'b0);
      axi_rd(msws_pkg::status_addr, rv);
      check(rv[0], 1'b1);
      wait_for(0, 1'b1, 40);
      repeat (200) @(posedge aclk);
      check(host_reset_n, 1'b1);
      check(drive_en, 1'b1);
      check(restarts != r0, 1'b1);
      axi_rd(msws_pkg::status_addr, rv);
      check(rv[0], 1'b1);
      axi_wr(msws_pkg::stclr_addr, 32'h1);
      axi_rd(msws_pkg::status_addr, rv);
      check(rv[0], 1'b0);
      hb_period <= 8'h03;
      wait_for(0, 1'b0, 100);
      hb_period <= 8'h00;
      axi_wr(msws_pkg::ctrl_addr, 32'h38);
      wait_for(0, 1'b1, 40);
      axi_wr(msws_pkg::stclr_addr, 32'h1);
      repeat (200) @(posedge aclk);
      check(host_reset_n, 1'b1);
      axi_rd(msws_pkg::status_addr, rv);
      check(rv[0], 1'b0);
      // fail-cycle limit of one, then the key switch wake ignored
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_wr(msws_pkg::wdcfg_addr, 32'h0001_0402);
      axi_wr(msws_pkg::ctrl_addr, 32'h00);
      wait_for(0, 1'b0, 100);
      wait_for(0, 1'b1, 40);
      check(regs_on, 1'b1);
      wait_for(1, 1'b0, 200);
      key_sw <= 1'b1;
      repeat (50) @(posedge aclk);
      check(regs_on, 1'b0);
      stop_test;
   end
endmodule
